// ==== include/tws_pkg.sv ====
// Purpose: shared constants and types for the two-wire slave block
// Assumes: 32-bit register bus, 8-bit registers in the low byte
// Notes: register offsets are byte addresses
package tws_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_DATA     = 8'h08;
	localparam logic [7:0] OFF_OWN      = 8'h0c;
	localparam logic [7:0] OFF_RATE     = 8'h10;
	localparam logic [7:0] OFF_IRQ_ST   = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	// control bit positions
	localparam int B_DONE = 0;
	localparam int B_ACK  = 1;
	localparam int B_EN   = 2;
	localparam int B_STA  = 3;
	localparam int B_STO  = 4;
	localparam int B_GCE  = 0; // in own_address_reg
	// interrupt status bits
	localparam int IRQ_W   = 3;
	localparam int I_DONE  = 0;
	localparam int I_STOP  = 1;
	localparam int I_START = 2;
	localparam logic [7:0] REG_RST   = 8'h00;
	localparam logic [7:0] DONE_MASK = 8'h01;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// bus status codes
	localparam logic [7:0] CODE_TX_ADDR      = 8'ha8;
	localparam logic [7:0] CODE_TX_ARB_ADDR  = 8'hb0;
	localparam logic [7:0] CODE_TX_DATA_ACK  = 8'hb8;
	localparam logic [7:0] CODE_TX_DATA_NACK = 8'hc0;
	localparam logic [7:0] CODE_TX_LAST_ACK  = 8'hc8;
	localparam logic [7:0] RX_ADDRESSED_ACKED_CODE = 8'h60;
	localparam logic [7:0] CODE_RX_ARB_ADDR  = 8'h68;
	localparam logic [7:0] CODE_RX_GC        = 8'h70;
	localparam logic [7:0] CODE_RX_ARB_GC    = 8'h78;
	localparam logic [7:0] RX_BYTE_ACKED_CODE  = 8'h80;
	localparam logic [7:0] RX_BYTE_NACKED_CODE = 8'h88;
	localparam logic [7:0] CODE_RX_GC_ACK    = 8'h90;
	localparam logic [7:0] CODE_RX_GC_NACK   = 8'h98;
	localparam logic [7:0] CODE_RX_STOP      = 8'ha0;
	localparam logic [7:0] CODE_NONE         = 8'hf8;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_ADDR    = 3'h1,
		ST_ACK_OUT = 3'h3,
		ST_HOLD    = 3'h2,
		ST_RX      = 3'h6,
		ST_TX      = 3'h7,
		ST_ACK_IN  = 3'h5
	} tws_state_t;
	// mapped register check for the bus slave
	function automatic logic tws_addr_ok(input logic [7:0] a);
		return a inside {OFF_CTRL, OFF_STATUS, OFF_DATA, OFF_OWN, OFF_RATE, OFF_IRQ_ST, OFF_IRQ_MASK};
	endfunction : tws_addr_ok
endpackage : tws_pkg

// ==== design/tws_sync.sv ====
// Purpose: two-flop synchroniser for line inputs
// Assumes: inputs are asynchronous to clock
// Notes: only the second stage may be read
`timescale 1ns/1ps
module tws_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	// one flop pair per bit, idle lines read high
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_q;
		always_ff @(posedge clock) begin
			if (!reset_n) begin
				meta_q  <= 1'b1;
				dout[i] <= 1'b1;
			end else if (ce) begin
				meta_q  <= din[i];
				dout[i] <= meta_q;
			end
		end
	end
endmodule : tws_sync

// ==== design/tws_axil.sv ====
// Purpose: AXI4-Lite slave front end producing register strobes
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer SLVERR
`timescale 1ns/1ps
module tws_axil
	import tws_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data
);
	logic aw_full_q;
	logic w_full_q;

	// address and data may arrive in either order
	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign wr_en         = ce && aw_full_q && w_full_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_en         = ce && s_axi_arvalid && !s_axi_rvalid;
	assign rd_addr       = s_axi_araddr;

	// write channel capture and response
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			wr_addr      <= '0;
			wr_data      <= '0;
			wr_strb      <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				wr_addr   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				wr_data  <= s_axi_wdata;
				wr_strb  <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= tws_addr_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (rd_en) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_data;
				s_axi_rresp  <= tws_addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : tws_axil

// ==== design/tws_slave.sv ====
// Purpose: two-wire slave receiver and transmitter with status codes
// Assumes: bus lines open drain, sampled through tws_sync
// Notes: master-mode logic lives elsewhere; it reports lost arbitration
// Behaviour
// R1: own address read acked gives A8, flag
// R2: arbitration lost then own read gives B0
// R3: sent byte acked gives B8
// R4: sent byte nacked gives C0
// R5: last byte still acked gives C8
// R6: clear with ack off sends last byte
// R7: clear with ack on sends byte, expects ack
// R8: software writes stop zero, flag one
// R9: C0/C8 ack off: unaddressed, no recognition
// R10: C0/C8 ack on: own address, gated general call
// R11: start request schedules START when bus free
// R12: clear with ack on acks next byte
// R13: clear with ack off nacks next byte
// R14: no next byte until flag cleared
// R15: after nack, clear returns to unaddressed mode
// R16: software enables with flag, ack, enable set
// R17: flag set stretches clock line low; the code does not stretch after a stop (A0)
`timescale 1ns/1ps
module tws_slave
	import tws_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	input  wire logic        arb_lost,
	output logic             start_issue,
	output logic             irq
);
	logic             wr_en;
	logic [7:0]       wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic             rd_en;
	logic [7:0]       rd_addr;
	logic [31:0]      rd_data;
	logic [1:0]       line_s;
	logic             scl_prev_q;
	logic             sda_prev_q;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_det;
	logic             stop_det;
	logic [7:0]       ctrl_q;
	logic [7:0]       own_q;
	logic [7:0]       rate_q;
	logic [7:0]       data_q;
	logic [IRQ_W-1:0] irq_st_q;
	logic [IRQ_W-1:0] irq_mask_q;
	logic             wr_ctl;
	logic             clr_ev;
	logic             clr_q;
	tws_state_t       state_q;
	logic [3:0]       cnt_q;
	logic [7:0]       shift_q;
	logic [7:0]       code_q;
	logic             flag_q;
	logic             flag_prev_q;
	logic             addr_ph_q;
	logic             rw_q;
	logic             gc_q;
	logic             arb_q;
	logic             ack_next_q;
	logic             last_q;
	logic             nack_q;
	logic             busy_q;
	logic             start_pend_q;
	logic             own_hit;
	logic             gc_hit;
	logic             tx_code;
	logic             end_code;
	logic             sda_low_q;
	logic             scl_hold_q;

	tws_axil u_axil (
		.clock         (clock),
		.reset_n       (reset_n),
		.ce            (ce),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data)
	);

	tws_sync #(.WIDTH(2)) u_sync (
		.clock   (clock),
		.reset_n (reset_n),
		.ce      (ce),
		.din     ({scl_i, sda_i}),
		.dout    (line_s)
	);

	// line edges and bus conditions from synchronised levels
	assign scl_rise  = line_s[1] && !scl_prev_q;
	assign scl_fall  = !line_s[1] && scl_prev_q;
	assign start_det = line_s[1] && scl_prev_q && sda_prev_q && !line_s[0];
	assign stop_det  = line_s[1] && scl_prev_q && !sda_prev_q && line_s[0];
	assign own_hit   = ctrl_q[B_ACK] && (shift_q[7:1] == own_q[7:1]); // [R10]
	assign gc_hit    = ctrl_q[B_ACK] && own_q[B_GCE] && (shift_q == REG_RST); // [R10]
	assign tx_code   = code_q inside {CODE_TX_ADDR, CODE_TX_ARB_ADDR, CODE_TX_DATA_ACK};
	assign end_code  = code_q inside {CODE_TX_DATA_NACK, CODE_TX_LAST_ACK,
		RX_BYTE_NACKED_CODE, CODE_RX_GC_NACK, CODE_RX_STOP};
	assign wr_ctl    = wr_en && (wr_addr == OFF_CTRL) && wr_strb[0];
	assign clr_ev    = wr_ctl && wr_data[B_DONE]; // [R14]

	// open drain: outputs are always low, enables pick the drive
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_n = !scl_hold_q;
	assign sda_oe_n = !sda_low_q;
	assign irq      = |(irq_st_q & irq_mask_q);

	// previous line levels for edge finding
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (ce) begin
			scl_prev_q <= line_s[1];
			sda_prev_q <= line_s[0];
		end
	end

	// software registers; the flag bit is kept by the sequencer
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl_q <= REG_RST;
			own_q  <= REG_RST;
			rate_q <= REG_RST;
			data_q <= REG_RST;
			clr_q  <= 1'b0;
		end else if (ce) begin
			clr_q <= clr_ev;
			if (wr_ctl)
				ctrl_q <= wr_data[7:0] & ~DONE_MASK;
			if (wr_en && wr_strb[0] && wr_addr == OFF_OWN)
				own_q <= wr_data[7:0];
			if (wr_en && wr_strb[0] && wr_addr == OFF_RATE)
				rate_q <= wr_data[7:0];
			if (wr_en && wr_strb[0] && wr_addr == OFF_DATA)
				data_q <= wr_data[7:0];
		end
	end

	// read mux; status shows no-info code while the flag is low
	always_comb begin
		rd_data = '0;
		case (rd_addr)
			OFF_CTRL:     rd_data[7:0] = ctrl_q | {7'h00, flag_q};
			OFF_STATUS:   rd_data[7:0] = flag_q ? code_q : CODE_NONE;
			OFF_DATA:     rd_data[7:0] = rw_q ? data_q : shift_q;
			OFF_OWN:      rd_data[7:0] = own_q;
			OFF_RATE:     rd_data[7:0] = rate_q;
			OFF_IRQ_ST:   rd_data[IRQ_W-1:0] = irq_st_q;
			OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
			default:      rd_data = '0;
		endcase
	end

	// byte sequencer; a set of the flag is written last so it beats a clear
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q    <= ST_IDLE;
			cnt_q      <= '0;
			shift_q    <= REG_RST;
			code_q     <= CODE_NONE;
			flag_q     <= 1'b0;
			addr_ph_q  <= 1'b0;
			rw_q       <= 1'b0;
			gc_q       <= 1'b0;
			ack_next_q <= 1'b0;
			last_q     <= 1'b0;
			nack_q     <= 1'b0;
		end else if (ce) begin
			if (clr_ev)
				flag_q <= 1'b0;
			if (!ctrl_q[B_EN]) begin
				state_q <= ST_IDLE;
			end else if (start_det && state_q != ST_HOLD) begin
				state_q <= ST_ADDR;
				cnt_q   <= '0;
			end else if (stop_det && state_q != ST_HOLD && state_q != ST_IDLE) begin
				// stop while addressed as receiver is reported once a data byte has come in, else dropped
				if (!rw_q && !addr_ph_q && state_q != ST_ADDR) begin
					code_q  <= CODE_RX_STOP;
					flag_q  <= 1'b1;
					state_q <= ST_HOLD;
				end else begin
					state_q <= ST_IDLE;
				end
			end else begin
				case (state_q)
					ST_ADDR: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], line_s[0]};
							cnt_q   <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == BYTE_BITS) begin
							cnt_q <= '0;
							if (own_hit || gc_hit) begin // [R10]
								state_q    <= ST_ACK_OUT;
								addr_ph_q  <= 1'b1;
								ack_next_q <= 1'b1;
								rw_q       <= shift_q[0];
								gc_q       <= !own_hit;
							end else begin
								state_q <= ST_IDLE; // [R9]
							end
						end
					end
					ST_RX: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], line_s[0]};
							cnt_q   <= cnt_q + 4'h1;
						end else if (scl_fall && cnt_q == BYTE_BITS) begin
							cnt_q     <= '0;
							addr_ph_q <= 1'b0;
							state_q   <= ST_ACK_OUT;
						end
					end
					ST_ACK_OUT: begin
						if (scl_fall) begin
							flag_q  <= 1'b1; // [R1]
							state_q <= ST_HOLD;
							if (addr_ph_q && rw_q)
								code_q <= arb_q ? CODE_TX_ARB_ADDR : CODE_TX_ADDR; // [R1] [R2]
							else if (addr_ph_q)
								code_q <= gc_q ? (arb_q ? CODE_RX_ARB_GC : CODE_RX_GC)
									: (arb_q ? CODE_RX_ARB_ADDR : RX_ADDRESSED_ACKED_CODE);
							else if (gc_q)
								code_q <= ack_next_q ? CODE_RX_GC_ACK : CODE_RX_GC_NACK;
							else
								code_q <= ack_next_q ? RX_BYTE_ACKED_CODE : RX_BYTE_NACKED_CODE;
						end
					end
					ST_HOLD: begin
						// nothing moves on the line until software clears the flag
						if (clr_q) begin // [R14]
							cnt_q <= '0;
							if (tx_code) begin
								state_q <= ST_TX;
								shift_q <= data_q;
								last_q  <= !ctrl_q[B_ACK]; // [R6] [R7]
							end else if (end_code) begin
								state_q <= ST_IDLE; // [R9] [R10] [R15]
							end else begin
								state_q    <= ST_RX;
								ack_next_q <= ctrl_q[B_ACK]; // [R12] [R13]
							end
						end
					end
					ST_TX: begin
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall) begin
							if (cnt_q == BYTE_BITS)
								state_q <= ST_ACK_IN;
							else
								shift_q <= {shift_q[6:0], 1'b1};
						end
					end
					ST_ACK_IN: begin
						if (scl_rise) begin
							nack_q <= line_s[0];
						end else if (scl_fall) begin
							flag_q  <= 1'b1;
							state_q <= ST_HOLD;
							if (nack_q)
								code_q <= CODE_TX_DATA_NACK; // [R4]
							else
								code_q <= last_q ? CODE_TX_LAST_ACK : CODE_TX_DATA_ACK; // [R3] [R5]
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// lost arbitration remembered until a stop or until the next address is answered
	always_ff @(posedge clock) begin
		if (!reset_n)
			arb_q <= 1'b0;
		else if (ce) begin
			if (arb_lost)
				arb_q <= 1'b1;
			else if (stop_det || (state_q == ST_HOLD && addr_ph_q && clr_q))
				arb_q <= 1'b0;
		end
	end

	// line drivers registered so pins never glitch
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sda_low_q  <= 1'b0;
			scl_hold_q <= 1'b0;
		end else if (ce) begin
			sda_low_q <= (state_q == ST_ACK_OUT && ack_next_q) // [R12] [R13]
				|| (state_q == ST_TX && !shift_q[7]); // [R7]
			// no stretch after a stop: the master has already left
			scl_hold_q <= state_q == ST_HOLD && code_q != CODE_RX_STOP; // [R17]
		end
	end

	// bus busy tracking and deferred start request
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			busy_q       <= 1'b0;
			start_pend_q <= 1'b0;
			start_issue  <= 1'b0;
		end else if (ce) begin
			if (start_det)
				busy_q <= 1'b1;
			else if (stop_det)
				busy_q <= 1'b0;
			start_issue <= start_pend_q && !busy_q; // [R11]
			if (state_q == ST_HOLD && clr_q && end_code && ctrl_q[B_STA])
				start_pend_q <= 1'b1; // [R11]
			else if (!busy_q)
				start_pend_q <= 1'b0;
		end
	end

	// sticky events, cleared by writing one; a new event wins
	// the flag event is its rising edge, so a flag still pending cannot re-arm a cleared bit
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			irq_st_q    <= '0;
			irq_mask_q  <= '0;
			flag_prev_q <= 1'b0;
		end else if (ce) begin
			flag_prev_q <= flag_q;
			if (wr_en && wr_strb[0] && wr_addr == OFF_IRQ_MASK)
				irq_mask_q <= wr_data[IRQ_W-1:0];
			irq_st_q <= (irq_st_q & ~((wr_en && wr_strb[0] && wr_addr == OFF_IRQ_ST)
				? wr_data[IRQ_W-1:0] : '0))
				| {start_pend_q && !busy_q, stop_det, flag_q && !flag_prev_q};
		end
	end

	property p_read_addr;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_ACK_OUT && scl_fall
			&& addr_ph_q && rw_q && !arb_q |=> flag_q && code_q == CODE_TX_ADDR;
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("no A8 after read address"); // [R1]

	property p_arb_addr;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_ACK_OUT && scl_fall
			&& addr_ph_q && rw_q && arb_q |=> code_q == CODE_TX_ARB_ADDR && state_q == ST_HOLD;
	endproperty
	a_arb_addr: assert property (p_arb_addr) else $error("no B0 after lost arbitration"); // [R2]

	property p_tx_ack;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_ACK_IN && scl_fall
			&& !nack_q && !last_q |=> code_q == CODE_TX_DATA_ACK ##1 scl_hold_q;
	endproperty
	a_tx_ack: assert property (p_tx_ack) else $error("no B8 with stretch"); // [R3]

	property p_tx_nack;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_ACK_IN && scl_fall
			&& nack_q |=> code_q == CODE_TX_DATA_NACK;
	endproperty
	a_tx_nack: assert property (p_tx_nack) else $error("no C0 after nack"); // [R4]

	property p_tx_last;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_ACK_IN && scl_fall
			&& !nack_q && last_q |=> code_q == CODE_TX_LAST_ACK;
	endproperty
	a_tx_last: assert property (p_tx_last) else $error("no C8 on acked last byte"); // [R5]

	property p_load_mode;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_HOLD && clr_q && tx_code
			|=> state_q == ST_TX && last_q == !$past(ctrl_q[B_ACK]) && shift_q == $past(data_q);
	endproperty
	a_load_mode: assert property (p_load_mode) else $error("bad byte load on clear"); // [R6] [R7]

	property p_leave;
		@(posedge clock) disable iff (!reset_n)
		ce && ctrl_q[B_EN] && !start_det && !stop_det && state_q == ST_HOLD && clr_q && end_code
			|=> state_q == ST_IDLE ##1 !scl_hold_q;
	endproperty
	a_leave: assert property (p_leave) else $error("not unaddressed after end code"); // [R9] [R10] [R15]

	property p_start_later;
		@(posedge clock) disable iff (!reset_n)
		ce && start_pend_q && !busy_q |=> start_issue;
	endproperty
	a_start_later: assert property (p_start_later) else $error("start not issued on free bus"); // [R11]

	property p_rx_ack;
		@(posedge clock) disable iff (!reset_n)
		ce && state_q == ST_ACK_OUT && ack_next_q && $stable(state_q) |=> !sda_oe_n;
	endproperty
	a_rx_ack: assert property (p_rx_ack) else $error("ack not driven"); // [R12]

	property p_rx_nack;
		@(posedge clock) disable iff (!reset_n)
		ce && state_q == ST_ACK_OUT && !ack_next_q |=> sda_oe_n;
	endproperty
	a_rx_nack: assert property (p_rx_nack) else $error("nack byte drove the data line"); // [R13]

	property p_hold_wait;
		@(posedge clock) disable iff (!reset_n)
		ce && state_q == ST_HOLD && !clr_q && ctrl_q[B_EN] && !start_det |=> state_q == ST_HOLD;
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("left hold without clear"); // [R14]

	property p_stretch;
		@(posedge clock) disable iff (!reset_n)
		ce && flag_q && state_q == ST_HOLD && code_q != CODE_RX_STOP ##1 ce && state_q == ST_HOLD
			|-> !scl_oe_n;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock not stretched"); // [R17]
endmodule : tws_slave

// ==== test/tws_bus_master.sv ====
// Purpose: behavioural two-wire bus master facing the slave
// Assumes: open-drain lines with pull-ups resolved in the bench
// Notes: 64 ns link period, clock stands still between frames
`timescale 1ns/1ps
module tws_bus_master (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_low,
	output logic      sda_low
);
	int tmo = 0;
	// both lines released while idle
	initial begin
		scl_low = 0;
		sda_low = 0;
	end
	// bounded wait for the clock line; the slave may stretch it
	task automatic hi();
		for (int n = 0; n < 9999 && !scl; n++) #8;
		if (!scl) tmo++;
	endtask : hi
	task automatic start();
		sda_low = 1;
		#16 scl_low = 1;
		#16;
	endtask : start
	task automatic stop();
		sda_low = 1;
		#16 scl_low = 0;
		#1 hi();
		#15 sda_low = 0;
		#32;
	endtask : stop
	// data changes only while the clock is low; the long low phase lets the slave turn its data line first
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#24 scl_low = 0;
		#1 hi();
		#7 r = sda;
		#16 scl_low = 1;
		#16;
	endtask : bit_io
	// eight bits msb first, then the acknowledge bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(a, ak);
	endtask : xfer
endmodule : tws_bus_master

// ==== test/tws_slave_test.sv ====
// Purpose: self-checking bench for the two-wire slave
// Assumes: one register access at a time, master model on the lines
// Notes: expected bytes kept in a queue, codes from the package
`timescale 1ns/1ps
module tws_slave_test;
	import tws_pkg::*;
	logic        clock = 0, reset_n = 0, ce = 1, arb_lost = 0, scl, sda, scl_low, sda_low;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        scl_o, scl_oe_n, sda_o, sda_oe_n, start_issue, irq, ak;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, q, d;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          errors = 0, checks_done = 0, n;
	int          exp_q[$];
	always #4 clock = ~clock;
	// open-drain wires: low if any party pulls
	assign scl = (scl_oe_n | scl_o) & !scl_low;
	assign sda = (sda_oe_n | sda_o) & !sda_low;
	tws_slave dut (.*, .scl_i(scl), .sda_i(sda));
	tws_bus_master m (.scl, .sda, .scl_low, .sda_low);
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int i;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		if (i == 50) errors++;
		chk("bresp", RESP_OKAY, s_axi_bresp);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int i;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (i = 0; i < 50 && !s_axi_rvalid; i++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
		if (i == 50) errors++;
	endtask : rd
	// wait for the interrupt, check the code, clear the sticky bit
	task automatic flag(input logic [7:0] e);
		for (int i = 0; i < 500 && !irq; i++) @(posedge clock);
		if (!irq) errors++;
		rd(OFF_STATUS, rv, r);
		chk("status", {24'h0, e}, rv);
		wr(OFF_IRQ_ST, 32'h1);
		chk("irq", 0, irq);
		$display("step done code %h", e);
	endtask : flag
	task automatic snd(input logic [31:0] c);
		d = 8'($urandom);
		exp_q.push_back(d);
		wr(OFF_DATA, {24'h0, d});
		wr(OFF_CTRL, c);
	endtask : snd
	task automatic get(input logic a);
		m.xfer(8'hff, a, q, ak);
		chk("tx byte", exp_q.pop_front(), q);
	endtask : get
	task automatic put(input logic [7:0] b, input logic e);
		m.xfer(b, 1'b1, q, ak);
		chk("ack", e, ak);
	endtask : put
	// main sequence: transmit, refused byte, receive
	initial begin
		void'($urandom(52645));
		repeat (3) @(posedge clock);
		reset_n <= 1;
		wr(OFF_OWN, 32'ha0);
		wr(OFF_IRQ_MASK, 32'h1);
		rd(8'h1c, rv, r);
		chk("resp", RESP_SLVERR, r);
		wr(OFF_CTRL, 32'h07);
		@(posedge clock) arb_lost <= 1;
		@(posedge clock) arb_lost <= 0;
		m.start();
		put(8'ha1, 0);
		flag(CODE_TX_ARB_ADDR);
		snd(32'h07);
		get(0);
		flag(CODE_TX_DATA_ACK);
		snd(32'h05);
		get(0);
		flag(CODE_TX_LAST_ACK);
		wr(OFF_CTRL, 32'h0f);
		fork
			m.stop();
			begin
				for (n = 0; n < 200 && !start_issue; n++) @(posedge clock);
				chk("start", 1, start_issue);
			end
		join
		m.start();
		put(8'ha1, 0);
		flag(CODE_TX_ADDR);
		snd(32'h07);
		get(1);
		flag(CODE_TX_DATA_NACK);
		wr(OFF_CTRL, 32'h05);
		m.stop();
		m.start();
		put(8'ha1, 1);
		m.stop();
		wr(OFF_CTRL, 32'h06);
		m.start();
		put(8'ha0, 0);
		flag(RX_ADDRESSED_ACKED_CODE);
		wr(OFF_CTRL, 32'h07);
		for (int i = 0; i < 2; i++) begin
			d = 8'($urandom);
			put(d, i[0]);
			flag(i[0] ? RX_BYTE_NACKED_CODE : RX_BYTE_ACKED_CODE);
			rd(OFF_DATA, rv, r);
			chk("rx byte", {24'h0, d}, rv);
			wr(OFF_CTRL, i[0] ? 32'h07 : 32'h05);
		end
		m.stop();
		m.start();
		put(8'ha0, 0);
		chk("line waits", 0, m.tmo);
		end_sim();
	end
	// hang guard
	initial begin
		#400000;
		errors++;
		end_sim();
	end
endmodule : tws_slave_test
